/* logic/cis_pkg.sv */
// package: constants, opcodes and register map of the instruction executor
package cis_pkg;
	localparam int unsigned PC_W = 12;
	localparam int unsigned MADR_W = 4;
	localparam int unsigned MEM_WORDS = 16;
	localparam int unsigned STK_DEPTH = 8;
	localparam int unsigned SP_W = 3;
	localparam int unsigned OP_W = 6;
	// register byte offsets
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_WORK = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_PC = 8'h0c;
	localparam logic [7:0] OFF_WDOG = 8'h10;
	localparam logic [7:0] OFF_SP = 8'h14;
	localparam logic [7:0] OFF_MEM = 8'h40;
	localparam logic [7:0] OFF_MEM_END = 8'h80;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// instruction word fields
	localparam int unsigned IF_OP = 0;
	localparam int unsigned IF_BIT = 6;
	localparam int unsigned IF_MADR = 12;
	localparam int unsigned IF_ARG = 16;
	// flag register bits
	localparam int unsigned FL_C = 0;
	localparam int unsigned FL_AC = 1;
	localparam int unsigned FL_Z = 2;
	localparam int unsigned FL_OV = 3;
	localparam int unsigned FL_SC = 4;
	localparam int unsigned FL_TO = 5;
	localparam int unsigned FL_PDF = 6;
	localparam int unsigned FL_GIE = 7;
	// reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 12'h000;
	// decimal adjust
	localparam logic [3:0] NIB_MAX = 4'h9;
	localparam logic [7:0] DAA_LO = 8'h06;
	localparam logic [7:0] DAA_HI = 8'h60;
	typedef enum logic [OP_W-1:0] {
		OP_IDLE = 6'h00, OP_ADD_WORK = 6'h01, OP_ADC_WORK = 6'h02, OP_ADD_IMM = 6'h03,
		OP_SUM_MEM = 6'h04, OP_SUM_CARRY_MEM = 6'h05, OP_AND_WORK = 6'h06, OP_AND_IMM = 6'h07,
		OP_CONJ_MEM = 6'h08, OP_OR_WORK = 6'h09, OP_OR_IMM = 6'h0a, OP_DISJ_MEM = 6'h0b,
		OP_CALL = 6'h0c, OP_ZERO_FILL = 6'h0d, OP_ZERO_BIT = 6'h0e, OP_WDT_CLR = 6'h0f,
		OP_INVERT = 6'h10, OP_INVERT_WORK = 6'h11, OP_DEC_ADJ = 6'h12, OP_DEC = 6'h13,
		OP_DEC_WORK = 6'h14, OP_INC = 6'h15, OP_INC_WORK = 6'h16, OP_SLEEP = 6'h17,
		OP_GOTO = 6'h18, OP_COPY_WORK = 6'h19, OP_COPY_IMM = 6'h1a, OP_COPY_MEM = 6'h1b,
		OP_RET = 6'h1c, OP_RET_IMM = 6'h1d, OP_IRQ_RET = 6'h1e, OP_ROTL = 6'h1f,
		OP_ROTL_WORK = 6'h20, OP_ROTLC = 6'h21, OP_ROTLC_WORK = 6'h22
	} cis_op_e;
endpackage

/* logic/cis_alu.sv */
// combinational operand and result stage of the instruction executor
`timescale 1ns/1ps
module cis_alu (
	input wire cis_pkg::cis_op_e op,
	input wire logic [7:0] work,
	input wire logic [7:0] mem,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_sel,
	input wire logic c_in,
	input wire logic ac_in,
	output logic [7:0] res,
	output logic wr_mem,
	output logic wr_work,
	output logic upd_arith,
	output logic upd_z,
	output logic upd_c,
	output logic c_out,
	output logic ac_out,
	output logic ov_out,
	output logic sc_out
);
	import cis_pkg::*;

	// {wrap, half carry, carry, sum}
	function automatic logic [10:0] add_f(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [4:0] lo;
		logic [7:0] s7;
		logic [8:0] s8;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
		s8 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		add_f = {s7[7] ^ s8[8], lo[4], s8};
	endfunction

	logic [10:0] sum;
	logic [7:0] add_a;
	logic [7:0] add_b;
	logic add_ci;
	logic lo_adj;
	logic hi_adj;

	always_comb begin
		lo_adj = (work[3:0] > NIB_MAX) || ac_in; // RQ11
		hi_adj = (work[7:4] > NIB_MAX) || c_in; // RQ11
		add_a = work;
		add_b = (op == OP_ADD_IMM) ? imm : mem;
		add_ci = (op == OP_ADC_WORK || op == OP_SUM_CARRY_MEM) ? c_in : 1'b0; // RQ1 RQ23
		if (op == OP_INC || op == OP_INC_WORK || op == OP_DEC || op == OP_DEC_WORK) begin
			add_a = mem;
			add_b = (op == OP_DEC || op == OP_DEC_WORK) ? 8'hff : 8'h01; // RQ12 RQ13
		end
		if (op == OP_DEC_ADJ) begin
			add_b = (hi_adj ? DAA_HI : 8'h00) | (lo_adj ? DAA_LO : 8'h00); // RQ11
		end
		sum = add_f(add_a, add_b, add_ci);
		res = 8'h00;
		wr_mem = 1'b0;
		wr_work = 1'b0;
		upd_arith = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		c_out = sum[8]; // RQ24
		ac_out = sum[9];
		ov_out = sum[10];
		sc_out = sum[10] ^ sum[7];
		case (op)
			OP_ADD_WORK, OP_ADC_WORK, OP_ADD_IMM: begin
				res = sum[7:0]; // RQ3 RQ23
				wr_work = 1'b1;
				upd_arith = 1'b1; // RQ2
			end
			OP_SUM_MEM, OP_SUM_CARRY_MEM: begin
				res = sum[7:0]; // RQ1
				wr_mem = 1'b1;
				upd_arith = 1'b1; // RQ2
			end
			OP_AND_WORK, OP_AND_IMM, OP_CONJ_MEM: begin
				res = work & ((op == OP_AND_IMM) ? imm : mem); // RQ4
				wr_mem = (op == OP_CONJ_MEM); // RQ5
				wr_work = (op != OP_CONJ_MEM);
				upd_z = 1'b1; // RQ4
			end
			OP_OR_WORK, OP_OR_IMM, OP_DISJ_MEM: begin
				res = work | ((op == OP_OR_IMM) ? imm : mem); // RQ4
				wr_mem = (op == OP_DISJ_MEM); // RQ5
				wr_work = (op != OP_DISJ_MEM);
				upd_z = 1'b1; // RQ4
			end
			OP_ZERO_FILL: wr_mem = 1'b1; // RQ7
			OP_ZERO_BIT: begin
				res = mem & ~(8'h01 << bit_sel); // RQ8
				wr_mem = 1'b1;
			end
			OP_INVERT, OP_INVERT_WORK: begin
				res = ~mem; // RQ10
				wr_mem = (op == OP_INVERT);
				wr_work = (op == OP_INVERT_WORK);
				upd_z = 1'b1;
			end
			OP_DEC_ADJ: begin
				res = sum[7:0]; // RQ11
				wr_mem = 1'b1;
				upd_c = 1'b1;
				c_out = hi_adj;
			end
			OP_DEC, OP_DEC_WORK, OP_INC, OP_INC_WORK: begin
				res = sum[7:0]; // RQ12 RQ13
				wr_mem = (op == OP_DEC || op == OP_INC);
				wr_work = (op == OP_DEC_WORK || op == OP_INC_WORK); // RQ22
				upd_z = 1'b1;
			end
			OP_COPY_WORK, OP_COPY_IMM, OP_RET_IMM: begin
				res = (op == OP_COPY_WORK) ? mem : imm; // RQ16 RQ18
				wr_work = 1'b1;
			end
			OP_COPY_MEM: begin
				res = work; // RQ16
				wr_mem = 1'b1;
			end
			OP_ROTL, OP_ROTL_WORK: begin
				res = {mem[6:0], mem[7]}; // RQ20
				wr_mem = (op == OP_ROTL);
				wr_work = (op == OP_ROTL_WORK);
			end
			OP_ROTLC, OP_ROTLC_WORK: begin
				res = {mem[6:0], c_in}; // RQ21
				wr_mem = (op == OP_ROTLC);
				wr_work = (op == OP_ROTLC_WORK);
				upd_c = 1'b1;
				c_out = mem[7]; // RQ21
			end
			default: res = 8'h00; // RQ17
		endcase
	end
endmodule

/* logic/cis_core.sv */
// instruction executor with AHB-Lite register access, data memory and return stack
//
// Functional notes
// RQ1 - memory add variants store work plus memory, plus carry if asked, in memory
// RQ2 - every add updates wrap, zero, half carry, carry and signed compare flags
// RQ3 - immediate add leaves work plus immediate byte in the work register
// RQ4 - and/or combine work with memory or immediate, touching only zero
// RQ5 - memory forms of and/or store their result into memory
// RQ6 - call pushes counter plus one, loads target, two cycles, no flags
// RQ7 - zero fill writes 00 to the addressed byte, flags untouched
// RQ8 - bit clear forces one selected bit low, others kept, no flags
// RQ9 - watchdog clear resets counter and clears timeout and sleep flags
// RQ10 - invert complements the memory byte into memory or work, zero only
// RQ11 - decimal adjust adds 00/06/60/66 to work, stores to memory, carry only
// RQ12 - decrement memory by one into memory or work, zero only
// RQ13 - increment memory by one into memory or work, zero only
// RQ14 - sleep halts execution, keeps state, clears watchdog, sets sleep flag
// RQ15 - goto loads the address field with one dummy cycle, no flags
// RQ16 - copy moves memory or immediate to work, or work to memory
// RQ17 - idle instruction only advances the counter
// RQ18 - return pops the counter; immediate form also loads work
// RQ19 - interrupt return pops, enables interrupts, pending interrupt serviced first
// RQ20 - rotate left moves bit 7 into bit 0, no flags
// RQ21 - rotate through carry: old carry into bit 0, bit 7 into carry
// RQ22 - results directed to work leave the memory byte unchanged
// RQ23 - add with carry to work sums work, memory and carry
// RQ24 - zero flag marks an all-zero result; carry is carry out of bit 7
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module cis_core #(
	parameter int unsigned PRE_W = 4,
	parameter int unsigned WDOG_W = 8,
	parameter logic [cis_pkg::PC_W-1:0] IRQ_VEC = 12'h004
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic irq_req,
	output logic core_sleeping,
	output logic global_irq_enable
);
	import cis_pkg::*;

	typedef enum {st_idle, st_exec, st_dummy, st_sleep} cis_st_e;

	function automatic logic mem_hit(input logic [7:0] adr);
		mem_hit = (adr >= OFF_MEM) && (adr < OFF_MEM_END) && (adr[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0] dmem [MEM_WORDS];
	logic [PC_W-1:0] stk [STK_DEPTH];
	cis_st_e st_ff, nxt_st;
	logic [31:0] instr_ff, nxt_instr;
	logic [7:0] work_ff, nxt_work;
	logic [7:0] flags_ff, nxt_flags;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic [SP_W-1:0] sp_ff, nxt_sp;
	logic [PRE_W-1:0] pre_ff, nxt_pre;
	logic [WDOG_W-1:0] wdog_ff, nxt_wdog;
	logic ph_wr_ff, nxt_ph_wr;
	logic nxt_ph_rd;
	logic [7:0] ph_adr_ff, nxt_ph_adr;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic irq_s1_ff, irq_s2_ff;
	logic mem_we, stk_we;
	logic [MADR_W-1:0] mem_wa, madr;
	logic [7:0] mem_wd, mem_rd, alu_res;
	logic [SP_W-1:0] stk_wa, sp_dec;
	logic [PC_W-1:0] stk_wd, tgt, pc_inc, pop_pc;
	cis_op_e op;
	logic ex, to_evt;
	logic alu_wr_mem, alu_wr_work, alu_upd_arith, alu_upd_z, alu_upd_c;
	logic alu_c, alu_ac, alu_ov, alu_sc;

	assign op = cis_op_e'(instr_ff[IF_OP +: OP_W]);
	assign madr = instr_ff[IF_MADR +: MADR_W];
	assign tgt = instr_ff[IF_ARG +: PC_W];
	assign mem_rd = dmem[madr];
	assign pc_inc = pc_ff + 12'h001;
	assign sp_dec = sp_ff - 3'h1;
	assign pop_pc = stk[sp_dec];
	assign ex = (st_ff == st_exec);
	// the timeout fires when prescaler and counter both wrap
	assign to_evt = (&pre_ff) && (&wdog_ff) && (st_ff != st_sleep);

	cis_alu u_alu (
		.op(op),
		.work(work_ff),
		.mem(mem_rd),
		.imm(instr_ff[IF_ARG +: 8]),
		.bit_sel(instr_ff[IF_BIT +: 3]),
		.c_in(flags_ff[FL_C]),
		.ac_in(flags_ff[FL_AC]),
		.res(alu_res),
		.wr_mem(alu_wr_mem),
		.wr_work(alu_wr_work),
		.upd_arith(alu_upd_arith),
		.upd_z(alu_upd_z),
		.upd_c(alu_upd_c),
		.c_out(alu_c),
		.ac_out(alu_ac),
		.ov_out(alu_ov),
		.sc_out(alu_sc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, reads registered in the address phase
	always_comb begin
		nxt_ph_wr = hsel && hready && htrans[1] && (hsize == HSIZE_WORD) && hwrite;
		nxt_ph_rd = hsel && hready && htrans[1] && (hsize == HSIZE_WORD) && !hwrite;
		nxt_ph_adr = haddr[7:0];
		nxt_hrdata = hrdata_ff;
		if (nxt_ph_rd) begin
			unique case (haddr[7:0])
				OFF_INSTR: nxt_hrdata = instr_ff;
				OFF_WORK: nxt_hrdata = {24'h000000, work_ff};
				OFF_FLAGS: nxt_hrdata = {22'h0, st_ff == st_sleep, st_ff != st_idle, flags_ff};
				OFF_PC: nxt_hrdata = {20'h00000, pc_ff};
				OFF_WDOG: nxt_hrdata = {{(32 - WDOG_W){1'b0}}, wdog_ff};
				OFF_SP: nxt_hrdata = {29'h0, sp_ff};
				default: nxt_hrdata = mem_hit(haddr[7:0]) ? {24'h000000, dmem[haddr[5:2]]} : 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ph_wr_ff <= 1'b0;
			ph_adr_ff <= 8'h00;
			hrdata_ff <= 32'h0;
		end else begin
			ph_wr_ff <= nxt_ph_wr;
			ph_adr_ff <= nxt_ph_adr;
			hrdata_ff <= nxt_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt request pin synchroniser
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_s1_ff <= 1'b0;
			irq_s2_ff <= 1'b0;
		end else begin
			irq_s1_ff <= irq_req;
			irq_s2_ff <= irq_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// execution
	always_comb begin
		nxt_st = st_ff;
		nxt_instr = instr_ff;
		nxt_work = work_ff;
		nxt_flags = flags_ff;
		nxt_pc = pc_ff;
		nxt_sp = sp_ff;
		nxt_pre = pre_ff;
		nxt_wdog = wdog_ff;
		mem_we = 1'b0;
		mem_wa = madr;
		mem_wd = alu_res;
		stk_we = 1'b0;
		stk_wa = sp_ff;
		stk_wd = pc_inc;
		// watchdog halts with the clock while asleep
		if (st_ff != st_sleep) begin
			nxt_pre = pre_ff + {{(PRE_W - 1){1'b0}}, 1'b1};
			if (&pre_ff) begin
				nxt_wdog = wdog_ff + {{(WDOG_W - 1){1'b0}}, 1'b1};
			end
		end
		// bus writes; an instruction is taken only when idle
		if (ph_wr_ff) begin
			unique case (ph_adr_ff)
				OFF_INSTR: begin
					if (st_ff == st_idle) begin
						nxt_instr = hwdata;
						nxt_st = st_exec;
					end
				end
				OFF_WORK: nxt_work = hwdata[7:0];
				OFF_FLAGS: nxt_flags = hwdata[7:0];
				OFF_PC: nxt_pc = hwdata[PC_W-1:0];
				default: begin
					if (mem_hit(ph_adr_ff)) begin
						mem_we = 1'b1;
						mem_wa = ph_adr_ff[5:2];
						mem_wd = hwdata[7:0];
					end
				end
			endcase
		end
		unique case (st_ff)
			st_idle: ;
			st_exec: begin
				nxt_st = st_idle;
				nxt_pc = pc_inc; // RQ17
				if (alu_wr_mem) begin
					mem_we = 1'b1; // RQ1 RQ5 RQ7 RQ8
					mem_wa = madr;
					mem_wd = alu_res;
				end
				if (alu_wr_work) begin
					nxt_work = alu_res; // RQ3 RQ22
				end
				if (alu_upd_arith) begin
					nxt_flags[FL_C] = alu_c; // RQ2 RQ24
					nxt_flags[FL_AC] = alu_ac;
					nxt_flags[FL_OV] = alu_ov;
					nxt_flags[FL_SC] = alu_sc;
				end
				if (alu_upd_arith || alu_upd_z) begin
					nxt_flags[FL_Z] = (alu_res == 8'h00); // RQ24
				end
				if (alu_upd_c) begin
					nxt_flags[FL_C] = alu_c; // RQ11 RQ21
				end
				unique case (op)
					OP_CALL: begin
						stk_we = 1'b1; // RQ6
						nxt_sp = sp_ff + 3'h1;
						nxt_pc = tgt;
						nxt_st = st_dummy;
					end
					OP_GOTO: begin
						nxt_pc = tgt; // RQ15
						nxt_st = st_dummy;
					end
					OP_RET, OP_RET_IMM: begin
						nxt_sp = sp_dec; // RQ18
						nxt_pc = pop_pc;
					end
					OP_IRQ_RET: begin
						// a pending request keeps the popped address stacked and vectors
						if (irq_s2_ff) begin
							nxt_pc = IRQ_VEC; // RQ19
							nxt_flags[FL_GIE] = 1'b0;
						end else begin
							nxt_sp = sp_dec; // RQ19
							nxt_pc = pop_pc;
							nxt_flags[FL_GIE] = 1'b1;
						end
					end
					OP_WDT_CLR, OP_SLEEP: begin
						nxt_pre = '0; // RQ9 RQ14
						nxt_wdog = '0;
						nxt_flags[FL_TO] = 1'b0;
						nxt_flags[FL_PDF] = (op == OP_SLEEP);
						if (op == OP_SLEEP) begin
							nxt_st = st_sleep; // RQ14
						end
					end
					default: ;
				endcase
			end
			st_dummy: nxt_st = st_idle; // RQ6 RQ15
			st_sleep: begin
				// only an interrupt request wakes the core
				if (irq_s2_ff) begin
					nxt_st = st_idle;
				end
			end
		endcase
		// a timeout wins over a clear in the same cycle
		if (to_evt) begin
			nxt_flags[FL_TO] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff <= st_idle;
			instr_ff <= 32'h0;
			work_ff <= WORK_RST;
			flags_ff <= FLAGS_RST;
			pc_ff <= PC_RST;
			sp_ff <= '0;
			pre_ff <= '0;
			wdog_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			instr_ff <= nxt_instr;
			work_ff <= nxt_work;
			flags_ff <= nxt_flags;
			pc_ff <= nxt_pc;
			sp_ff <= nxt_sp;
			pre_ff <= nxt_pre;
			wdog_ff <= nxt_wdog;
		end
	end

	// arrays hold no reset: contents survive sleep and are software-defined
	always_ff @(posedge clock) begin
		if (mem_we) begin
			dmem[mem_wa] <= mem_wd;
		end
		if (stk_we) begin
			stk[stk_wa] <= stk_wd;
		end
	end

	assign core_sleeping = (st_ff == st_sleep);
	assign global_irq_enable = flags_ff[FL_GIE];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] rotl_chk;
	logic [3:0] arith_bits;
	assign rotl_chk = {mem_rd[6:0], mem_rd[7]};
	assign arith_bits = {flags_ff[FL_SC], flags_ff[FL_OV], flags_ff[FL_AC], flags_ff[FL_C]};

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	sequence s_dummy_then_idle;
		##1 (st_ff == st_dummy && pc_ff == tgt) ##1 (st_ff == st_idle && pc_ff == tgt);
	endsequence
	sequence s_asleep;
		(st_ff == st_sleep && flags_ff[FL_PDF] && !flags_ff[FL_TO] && wdog_ff == '0);
	endsequence

	mem_sum_store_a: assert property ((ex && alu_wr_mem) |=> dmem[madr] == $past(alu_res)) // RQ1
		else $error("memory result not stored");
	arith_flags_a: assert property ((ex && alu_upd_arith && !to_evt) |=>
		(flags_ff[FL_C] == $past(alu_c)) && (flags_ff[FL_Z] == ($past(alu_res) == 8'h00))) // RQ2
		else $error("add flags wrong");
	zero_only_a: assert property ((ex && alu_upd_z) |=>
		$stable(arith_bits) && (flags_ff[FL_Z] == ($past(alu_res) == 8'h00))) // RQ4
		else $error("logic op touched other flags");
	call_seq_a: assert property ((ex && op == OP_CALL) |-> s_dummy_then_idle) // RQ6
		else $error("call timing wrong");
	goto_seq_a: assert property ((ex && op == OP_GOTO) |->
		s_dummy_then_idle ##0 $stable({flags_ff[FL_GIE:FL_PDF], flags_ff[FL_SC:FL_C]})) // RQ15
		else $error("goto timing wrong");
	wdt_clear_a: assert property ((ex && op == OP_WDT_CLR && !to_evt) |=>
		!flags_ff[FL_TO] && !flags_ff[FL_PDF] && wdog_ff == '0 && pre_ff == '0) // RQ9
		else $error("watchdog clear wrong");
	halt_enter_a: assert property ((ex && op == OP_SLEEP) |=>
		s_asleep ##1 (st_ff != st_sleep || $stable(pc_ff))) // RQ14
		else $error("sleep entry wrong");
	src_kept_a: assert property ((ex && alu_wr_work && !alu_wr_mem) |=>
		dmem[madr] == $past(mem_rd)) // RQ22
		else $error("source byte modified");
	rot_left_a: assert property ((ex && op == OP_ROTL_WORK) |=> work_ff == $past(rotl_chk)) // RQ20
		else $error("rotate left wrong");
	irq_ret_a: assert property ((ex && op == OP_IRQ_RET && !irq_s2_ff) |=>
		flags_ff[FL_GIE] && pc_ff == $past(pop_pc)) // RQ19
		else $error("interrupt return wrong");
endmodule

/* verif/cis_irq_src.sv */
// interrupt source model driving the core's request pin
`timescale 1ns/1ps
module cis_irq_src (
	input wire logic clock,
	input wire logic raise,
	output logic irq_req
);
	// level request, changed only just after an edge and held until withdrawn
	always_ff @(posedge clock) begin
		irq_req <= raise;
	end
endmodule

/* verif/cpu_instruction_semantics_bench.sv */
// self-checking bench for the instruction executor
`timescale 1ns/1ps
module cpu_instruction_semantics_bench;
	import cis_pkg::*;
	logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp, irq_raise, irq_req;
	logic core_sleeping, global_irq_enable;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] w, m, f, e_w, e_m, e_f;
	int n_fail, tests_run;
	cis_op_e ops[$] = '{OP_IDLE, OP_ADD_WORK, OP_ADC_WORK, OP_ADD_IMM, OP_SUM_MEM,
		OP_SUM_CARRY_MEM, OP_AND_WORK, OP_AND_IMM, OP_CONJ_MEM, OP_OR_WORK, OP_OR_IMM,
		OP_DISJ_MEM, OP_ZERO_FILL, OP_ZERO_BIT, OP_INVERT, OP_INVERT_WORK, OP_DEC_ADJ, OP_DEC,
		OP_DEC_WORK, OP_INC, OP_INC_WORK, OP_COPY_WORK, OP_COPY_IMM, OP_COPY_MEM, OP_ROTL,
		OP_ROTL_WORK, OP_ROTLC, OP_ROTLC_WORK};
	// short watchdog so a timeout is reached within the run
	cis_core #(.PRE_W(2), .WDOG_W(3)) dut (.clock(clock), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq_req(irq_req), .core_sleeping(core_sleeping),
		.global_irq_enable(global_irq_enable));
	cis_irq_src irq (.clock(clock), .raise(irq_raise), .irq_req(irq_req));
	assign hready = hreadyout;
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'h0;
		wait_rdy();
		d = hrdata;
	endtask
	// issue one instruction, then poll busy for up to 20 reads so the next one is not dropped unless the core sleeps
	task automatic run(input cis_op_e op, input logic [3:0] a, input logic [11:0] arg,
		input logic [2:0] b);
		int k;
		wr(OFF_INSTR, {4'h0, arg, a, 3'h0, b, op});
		k = 0;
		do begin
			rdr(OFF_FLAGS, rd);
			k++;
		end while (rd[8] !== 1'b0 && k < 20);
		if (rd[8] !== 1'b0 && !core_sleeping) n_fail++;
	endtask
	function automatic logic [7:0] madr(input logic [3:0] a);
		return OFF_MEM + {2'b00, a, 2'b00};
	endfunction
	function automatic void predict(input cis_op_e op, input logic [7:0] x, input logic [2:0] b);
		logic [8:0] s;
		logic [7:0] y, r;
		logic cin, lo, hi, wrap, zf;
		y = (op inside {OP_ADD_IMM, OP_AND_IMM, OP_OR_IMM}) ? x : m;
		cin = (op inside {OP_ADC_WORK, OP_SUM_CARRY_MEM}) & f[FL_C];
		s = {1'b0, w} + {1'b0, y} + {8'h0, cin};
		wrap = (w[7] == y[7]) && (s[7] != w[7]);
		lo = (w[3:0] > NIB_MAX) || f[FL_AC];
		hi = (w[7:4] > NIB_MAX) || f[FL_C];
		e_f = f;
		e_w = w;
		e_m = m;
		zf = 1'b1;
		r = m;
		case (op)
			OP_ADD_WORK, OP_ADC_WORK, OP_ADD_IMM, OP_SUM_MEM, OP_SUM_CARRY_MEM: begin
				r = s[7:0];
				e_f[FL_C] = s[8];
				e_f[FL_AC] = ({1'b0, w[3:0]} + {1'b0, y[3:0]} + {4'h0, cin}) > 5'h0f;
				e_f[FL_OV] = wrap;
				e_f[FL_SC] = wrap ^ s[7];
			end
			OP_AND_WORK, OP_AND_IMM, OP_CONJ_MEM: r = w & y;
			OP_OR_WORK, OP_OR_IMM, OP_DISJ_MEM: r = w | y;
			OP_INVERT, OP_INVERT_WORK: r = ~m;
			OP_DEC, OP_DEC_WORK: r = m - 8'h01;
			OP_INC, OP_INC_WORK: r = m + 8'h01;
			default: zf = 1'b0;
		endcase
		case (op)
			OP_ZERO_FILL: r = 8'h00;
			OP_ZERO_BIT: r[b] = 1'b0;
			OP_DEC_ADJ: r = w + {1'b0, hi, hi, 2'b00, lo, lo, 1'b0};
			OP_COPY_IMM: r = x;
			OP_COPY_MEM, OP_IDLE: r = w;
			OP_ROTL, OP_ROTL_WORK: r = {m[6:0], m[7]};
			OP_ROTLC, OP_ROTLC_WORK: r = {m[6:0], f[FL_C]};
			default: ;
		endcase
		if (op inside {OP_ROTLC, OP_ROTLC_WORK})
			e_f[FL_C] = m[7];
		if (op == OP_DEC_ADJ)
			e_f[FL_C] = hi;
		if (zf)
			e_f[FL_Z] = (r == 8'h00);
		if (op inside {OP_SUM_MEM, OP_SUM_CARRY_MEM, OP_CONJ_MEM, OP_DISJ_MEM, OP_ZERO_FILL,
			OP_ZERO_BIT, OP_INVERT, OP_DEC_ADJ, OP_DEC, OP_INC, OP_COPY_MEM, OP_ROTL, OP_ROTLC})
			e_m = r;
		else
			e_w = r;
	endfunction
	////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge clock);
		n_fail++;
		print_verdict();
	end
	initial begin
		int c;
		logic [3:0] a;
		logic [2:0] b;
		logic [7:0] x;
		nrst = 1'b0;
		hsel = 1'b1;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		irq_raise = 1'b0;
		n_fail = 0;
		tests_run = 0;
		void'($urandom(32'h5536));
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rdr(OFF_FLAGS, rd);
		chk(rd, 32'h0);
		rdr(OFF_WORK, rd);
		chk(rd, 32'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'h0);
		chk({30'h0, hresp, hreadyout}, 32'h1);
		// byte-sized, unselected and unmapped writes must all leave no trace
		hsize <= 3'h0;
		wr(OFF_WORK, 32'h77);
		hsize <= HSIZE_WORD;
		hsel <= 1'b0;
		wr(OFF_WORK, 32'h55);
		hsel <= 1'b1;
		wr(8'h30, 32'hffffffff);
		rdr(OFF_WORK, rd);
		chk(rd, 32'h0);
		rdr(8'h30, rd);
		chk(rd, 32'h0);
		// first pass uses fixed corner work, memory and flag values, later passes random ones
		for (int i = 0; i < 8 * ops.size(); i++) begin
			c = i % ops.size();
			a = 4'($urandom_range(15));
			b = 3'($urandom_range(7));
			x = 8'($urandom);
			w = (i < ops.size()) ? 8'h01 : 8'($urandom);
			m = (i < ops.size()) ? 8'hff : 8'($urandom);
			f = (i < ops.size()) ? 8'h1f : {3'h0, 5'($urandom)};
			predict(ops[c], x, b);
			wr(madr(a), {24'h0, m});
			wr(OFF_WORK, {24'h0, w});
			wr(OFF_FLAGS, {24'h0, f});
			run(ops[c], a, {4'h0, x}, b);
			rdr(OFF_WORK, rd);
			chk(rd, {24'h0, e_w});
			rdr(OFF_FLAGS, rd);
			chk(rd & 32'h1f, {27'h0, e_f[4:0]});
			rdr(madr(a), rd);
			chk(rd, {24'h0, e_m});
		end
		wr(OFF_FLAGS, 32'h40);
		repeat (40) @(posedge clock);
		rdr(OFF_FLAGS, rd);
		chk(rd & 32'h60, 32'h60);
		run(OP_WDT_CLR, 4'h0, 12'h0, 3'h0);
		run(OP_WDT_CLR, 4'h0, 12'h0, 3'h0);
		rdr(OFF_WDOG, rd);
		chk(rd >> 1, 32'h0);
		rdr(OFF_FLAGS, rd);
		chk(rd & 32'h60, 32'h0);
		wr(OFF_WORK, 32'h3c);
		run(OP_SLEEP, 4'h0, 12'h0, 3'h0);
		chk({31'h0, core_sleeping}, 32'h1);
		run(OP_COPY_IMM, 4'h0, 12'h05a, 3'h0);
		repeat (40) @(posedge clock);
		rdr(OFF_FLAGS, rd);
		chk(rd & 32'h60, 32'h40);
		rdr(OFF_WORK, rd);
		chk(rd, 32'h3c);
		irq_raise <= 1'b1;
		repeat (6) @(posedge clock);
		chk({31'h0, core_sleeping}, 32'h0);
		irq_raise <= 1'b0;
		repeat (4) @(posedge clock);
		wr(OFF_PC, 32'h123);
		run(OP_CALL, 4'h0, 12'hab5, 3'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'hab5);
		rdr(OFF_SP, rd);
		chk(rd, 32'h1);
		run(OP_GOTO, 4'h0, 12'h7f0, 3'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'h7f0);
		run(OP_RET_IMM, 4'h0, 12'h0c3, 3'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'h124);
		rdr(OFF_WORK, rd);
		chk(rd, 32'hc3);
		run(OP_IDLE, 4'h0, 12'h0, 3'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'h125);
		wr(OFF_FLAGS, 32'h80);
		run(OP_CALL, 4'h0, 12'h200, 3'h0);
		irq_raise <= 1'b1;
		repeat (4) @(posedge clock);
		run(OP_IRQ_RET, 4'h0, 12'h0, 3'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'h004);
		chk({31'h0, global_irq_enable}, 32'h0);
		irq_raise <= 1'b0;
		repeat (4) @(posedge clock);
		run(OP_IRQ_RET, 4'h0, 12'h0, 3'h0);
		rdr(OFF_PC, rd);
		chk(rd, 32'h126);
		chk({31'h0, global_irq_enable}, 32'h1);
		print_verdict();
	end
endmodule
